// ===== shared/nvsram_map.vh
// Purpose: constants for the host-side controller of a battery-backed 32K x 8 memory
// Assumes: 250 MHz clock, 4 ns period
// Notes: bus times in nanoseconds, lockout in milliseconds, cycle counts derived from them
`ifndef NVSRAM_MAP_VH
`define NVSRAM_MAP_VH

// =====================================================================
// clock
`define CLK_PERIOD_NS 4
// =====================================================================
// bus timing (host side), nanoseconds
`define ADDRESS_ACCESS_TIME_NS 100
`define WRITE_PULSE_NS 75
`define ADDR_SETUP_NS 4
`define WRITE_RECOVERY_TIME_NS 10
// least times round up
`define ACCESS_CYCLES ((`ADDRESS_ACCESS_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WRITE_PULSE_CYCLES ((`WRITE_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SETUP_CYCLES ((`ADDR_SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RECOVERY_CYCLES ((`WRITE_RECOVERY_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// =====================================================================
// power-up lockout, milliseconds
`define POWER_UP_LOCKOUT_TIME_MS 125
`define LOCKOUT_CYCLES (`POWER_UP_LOCKOUT_TIME_MS * 1000000 / `CLK_PERIOD_NS)
// =====================================================================
// field widths and cycle counter
`define ADDR_W 15
`define DATA_W 8
`define CNT_W 26
`define CNT_ONE 26'h0000001
`define CNT_ZERO 26'h0000000

`endif

// ===== src/cycle_timer.v
// Purpose: loadable down-counter that reports when a wait has run out
// Assumes: load has priority over counting
// Notes: done is high while the count stands at zero
`include "nvsram_map.vh"
`default_nettype none

module cycle_timer #(
	parameter W = `CNT_W
) (
	// clock and reset
	input wire clk,
	input wire resetn,
	// control
	input wire load,
	input wire [W-1:0] value,
	// status
	output wire done
);
	reg [W-1:0] count;

	// =====================================================================
	// counter
	// count down to zero and rest there
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			count <= {W{1'b0}};
		end else if (load) begin
			count <= value;
		end else if (count != {W{1'b0}}) begin
			count <= count - {{(W-1){1'b0}}, 1'b1};
		end
	end

	assign done = (count == {W{1'b0}});
endmodule // cycle_timer

`default_nettype wire

// ===== src/nvsram_host.v
// Purpose: host controller driving a battery-backed 32K x 8 asynchronous memory
// Assumes: device pins are sampled synchronously; power_good models the supply
// Notes: one request at a time; request is taken when req_ready is high
//
// Notes on behaviour
// R1: device reads while write enable high and select low; drives data when gate low.
// R2: fifteen address lines pick one of 32,768 bytes.
// R3: select high means standby; device floats data and ignores other strobes.
// R4: a write begins when both select and write enable are low.
// R5: a write ends on first rising strobe; data then is stored.
// R6: host holds address stable before and through the whole write.
// R7: host keeps write enable high for write recovery time between cycles.
// R8: host keeps output gate high during writes to avoid contention.
// R9: device floats data within write output-off time after write enable falls.
// R10: out-of-tolerance supply blocks writes and floats device outputs.
// R11: host waits the power-up lockout time after supply becomes valid.
// R12: device pulls supervisor reset low when supply falls below trip.
// R13: supervisor reset stays low until supply falls below battery.
// R14: on power-up reset stays low for a timeout longer than lockout.
// R15: reset release delay is 225 ms min, 350 typical, 525 max.
// R16: write protection ends no later than 125 ms after supply valid.
// R17: device inactivates strobes within 1.5 us and asserts reset within 3 us.
// R18: supervisor reset is open drain; external pull-up gives the high.
// R19: supply is one power-good input; timers run from its edges.
`include "nvsram_map.vh"
`default_nettype none

module nvsram_host #(
	parameter ADDR_W = `ADDR_W,
	parameter DATA_W = `DATA_W,
	parameter [`CNT_W-1:0] LOCKOUT_CYCLES = `LOCKOUT_CYCLES
) (
	// clock and reset
	input wire clk,
	input wire resetn,
	// supply and supervisor
	input wire power_good,
	input wire supervisor_reset_n,
	// user request
	input wire req_valid,
	input wire req_write,
	input wire [ADDR_W-1:0] req_addr,
	input wire [DATA_W-1:0] req_wdata,
	output wire req_ready,
	output reg rsp_valid,
	output reg [DATA_W-1:0] rsp_rdata,
	output reg mem_available,
	// memory pins
	output reg [ADDR_W-1:0] address_lines,
	output reg chip_select_n,
	output reg write_enable_n,
	output reg output_gate_n,
	input wire [DATA_W-1:0] data_lines_in,
	output reg [DATA_W-1:0] data_lines_out,
	output reg data_lines_oe
);
	// =====================================================================
	// states
	localparam [2:0] ST_LOCK = 3'h0;
	localparam [2:0] ST_IDLE = 3'h1;
	localparam [2:0] ST_READ = 3'h2;
	localparam [2:0] ST_WSETUP = 3'h3;
	localparam [2:0] ST_WPULSE = 3'h4;
	localparam [2:0] ST_WHOLD = 3'h5;
	localparam [2:0] ST_RECOVER = 3'h6;

	// timer loads sized to the counter so no bits are dropped silently
	localparam [`CNT_W-1:0] SETUP_CNT = `SETUP_CYCLES;
	localparam [`CNT_W-1:0] ACCESS_CNT = `ACCESS_CYCLES;
	localparam [`CNT_W-1:0] PULSE_CNT = `WRITE_PULSE_CYCLES;
	localparam [`CNT_W-1:0] RECOVERY_CNT = `RECOVERY_CYCLES;

	reg [2:0] state;
	reg [2:0] next_state;
	reg power_good_q;
	reg tmr_load;
	reg [`CNT_W-1:0] tmr_value;
	wire tmr_done;
	wire power_rise;
	wire access_ok;

	// =====================================================================
	// power-good tracking
	// a rising edge of power_good restarts the lockout wait
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			power_good_q <= 1'b0;
		end else begin
			power_good_q <= power_good;
		end
	end
	assign power_rise = power_good & ~power_good_q; // see R19

	// supervisor reset low also vetoes access; it outlasts the lockout anyway
	assign access_ok = power_good & supervisor_reset_n; // see R10, see R12, see R18

	// =====================================================================
	// shared wait timer: lockout, access, pulse and recovery times
	cycle_timer #(
		.W(`CNT_W)
	) u_timer (
		.clk(clk),
		.resetn(resetn),
		.load(tmr_load),
		.value(tmr_value),
		.done(tmr_done)
	);

	assign req_ready = (state == ST_IDLE) && access_ok;

	// =====================================================================
	// next state and timer loads
	always @* begin
		next_state = state;
		tmr_load = 1'b0;
		tmr_value = `CNT_ZERO;
		if (power_rise) begin
			next_state = ST_LOCK;
			tmr_load = 1'b1;
			tmr_value = LOCKOUT_CYCLES; // see R11, see R16
		end else if (!access_ok) begin
			// supply lost or supervisor reset low: abandon any cycle, strobes go inactive at the next edge
			next_state = ST_LOCK; // see R10, see R17
		end else begin
			case (state)
			ST_LOCK: begin
				if (tmr_done) begin
					next_state = ST_IDLE; // see R11
				end
			end
			ST_IDLE: begin
				if (req_valid) begin
					tmr_load = 1'b1;
					if (req_write) begin
						next_state = ST_WSETUP;
						tmr_value = SETUP_CNT; // see R6
					end else begin
						next_state = ST_READ;
						tmr_value = ACCESS_CNT; // see R1
					end
				end
			end
			ST_READ: begin
				if (tmr_done) begin
					next_state = ST_RECOVER;
					tmr_load = 1'b1;
					tmr_value = RECOVERY_CNT;
				end
			end
			ST_WSETUP: begin
				if (tmr_done) begin
					next_state = ST_WPULSE;
					tmr_load = 1'b1;
					tmr_value = PULSE_CNT; // see R4
				end
			end
			ST_WPULSE: begin
				if (tmr_done) begin
					next_state = ST_WHOLD; // see R5
				end
			end
			ST_WHOLD: begin
				next_state = ST_RECOVER;
				tmr_load = 1'b1;
				tmr_value = RECOVERY_CNT; // see R7
			end
			ST_RECOVER: begin
				if (tmr_done) begin
					next_state = ST_IDLE; // see R7
				end
			end
			default: begin
				next_state = ST_LOCK;
			end
			endcase
		end
	end

	// =====================================================================
	// state register and pin drivers
	// pins come from flops so no glitch reaches the asynchronous memory
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state <= ST_LOCK;
			address_lines <= {ADDR_W{1'b0}};
			chip_select_n <= 1'b1;
			write_enable_n <= 1'b1;
			output_gate_n <= 1'b1;
			data_lines_out <= {DATA_W{1'b0}};
			data_lines_oe <= 1'b0;
			rsp_valid <= 1'b0;
			rsp_rdata <= {DATA_W{1'b0}};
			mem_available <= 1'b0;
		end else begin
			state <= next_state;
			rsp_valid <= 1'b0;
			mem_available <= (next_state != ST_LOCK);
			if (state == ST_IDLE && next_state != ST_LOCK && req_valid) begin
				address_lines <= req_addr; // see R2, see R6
				data_lines_out <= req_wdata;
			end
			case (next_state)
			ST_READ: begin
				chip_select_n <= 1'b0;
				write_enable_n <= 1'b1;
				output_gate_n <= 1'b0; // see R1
				data_lines_oe <= 1'b0;
			end
			ST_WSETUP: begin
				chip_select_n <= 1'b0;
				write_enable_n <= 1'b1;
				output_gate_n <= 1'b1; // see R8, see R9
				data_lines_oe <= 1'b1;
			end
			ST_WPULSE: begin
				chip_select_n <= 1'b0;
				write_enable_n <= 1'b0; // see R4
				output_gate_n <= 1'b1; // see R8
				data_lines_oe <= 1'b1;
			end
			ST_WHOLD: begin
				// write enable rises first with data and address still held
				chip_select_n <= 1'b0;
				write_enable_n <= 1'b1; // see R5
				output_gate_n <= 1'b1;
				data_lines_oe <= 1'b1;
			end
			default: begin
				chip_select_n <= 1'b1; // see R3
				write_enable_n <= 1'b1;
				output_gate_n <= 1'b1;
				data_lines_oe <= 1'b0;
			end
			endcase
			// capture read data at the end of the access time
			if (state == ST_READ && next_state == ST_RECOVER) begin
				rsp_rdata <= data_lines_in; // see R1
				rsp_valid <= 1'b1;
			end
			if (state == ST_WHOLD && next_state == ST_RECOVER) begin
				rsp_valid <= 1'b1;
			end
		end
	end
endmodule // nvsram_host

`default_nettype wire

// ===== verification/nvsram_host_sva.sv
// Purpose: pin protocol checks for the memory host
// Assumes: one clock, resetn async active low
// Notes: recovery of 3 cycles follows the 10 ns choice
`default_nettype none
module nvsram_host_checks (
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// supply and user side
	input wire logic power_good,
	input wire logic supervisor_reset_n,
	input wire logic req_ready,
	// memory pins
	input wire logic [14:0] address_lines,
	input wire logic chip_select_n,
	input wire logic write_enable_n,
	input wire logic output_gate_n,
	input wire logic data_lines_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========
	// host obligations
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	property p_gate; !write_enable_n |-> output_gate_n; endproperty
	a_gate: assert property (p_gate) else $error("gate low in write");
	property p_addr; !write_enable_n |=> write_enable_n || $stable(address_lines); endproperty
	a_addr: assert property (p_addr) else $error("address moved in write");
	property p_recov; $rose(write_enable_n) |-> write_enable_n [*3]; endproperty
	a_recov: assert property (p_recov) else $error("recovery too short");
	property p_pwr; !power_good |=> chip_select_n && write_enable_n && !data_lines_oe; endproperty
	a_pwr: assert property (p_pwr) else $error("pins live off supply");
	property p_ready; !supervisor_reset_n |=> !req_ready; endproperty
	a_ready: assert property (p_ready) else $error("ready in reset");
	property p_wdrive; !write_enable_n |-> data_lines_oe; endproperty
	a_wdrive: assert property (p_wdrive) else $error("write data undriven");
	property p_wsel; !write_enable_n |-> !chip_select_n; endproperty
	a_wsel: assert property (p_wsel) else $error("write without select");
	property p_lock; $rose(power_good) |-> !req_ready [*8]; endproperty
	a_lock: assert property (p_lock) else $error("access in lockout");
endmodule // nvsram_host_checks
bind nvsram_host nvsram_host_checks i_nvsram_host_checks (.clk, .resetn, .power_good,
	.supervisor_reset_n, .req_ready, .address_lines, .chip_select_n, .write_enable_n,
	.output_gate_n, .data_lines_oe);
`default_nettype wire

// ===== verification/nvsram_device_model.sv
// Purpose: behavioural battery-backed 32K x 8 memory with supervisor
// Assumes: power_good stands for the supply; timers count clk cycles
// Notes: an undriven wire shows the inverse of its last value
`default_nettype none
module nvsram_device_model #(
	parameter int LOCK = 20,
	parameter int RST_DLY = 40,
	parameter int ACC = 24
) (
	// clock and supply
	input wire logic clk,
	input wire logic power_good,
	// memory pins
	input wire logic [14:0] address_lines,
	input wire logic chip_select_n,
	input wire logic write_enable_n,
	input wire logic output_gate_n,
	input wire logic [7:0] data_lines_out,
	input wire logic data_lines_oe,
	output logic [7:0] data_lines_in,
	output logic rst_pull
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========
	// storage and timers
	logic [7:0] mem [0:32767];
	int up = 0;
	int sel = 0;
	logic [7:0] last = 8'h00;
	logic drive;
	// both timers restart from edges of the supply and of select
	always @(posedge clk) begin
		up <= power_good ? up + 1 : 0;
		sel <= chip_select_n ? 0 : sel + 1;
		last <= data_lines_in;
	end
	assign rst_pull = !power_good || up < RST_DLY;
	assign drive = power_good && !chip_select_n && write_enable_n && !output_gate_n;
	// stale data before the access time is garbage, the inverse of the last cycle's value
	assign data_lines_in = data_lines_oe ? data_lines_out :
		(drive && sel >= ACC) ? mem[address_lines] : ~last;
	// store at the first rising strobe unless protected
	always @(posedge write_enable_n or posedge chip_select_n)
		if (power_good && up >= LOCK && !(write_enable_n && chip_select_n))
			mem[address_lines] <= data_lines_in;
endmodule // nvsram_device_model
`default_nettype wire

// ===== verification/nvsram_host_bench.sv
// Purpose: self-checking bench for the memory host
// Assumes: device model on the memory pins
// Notes: lockout shortened to 20 cycles
`default_nettype none
`define CHK(g, e, m) begin compares++; if ((g) !== (e)) begin err_total++; \
	$display("wrong value at %0t: %s", $time, m); end end
module nvsram_host_bench;
	timeunit 1ns;
	timeprecision 1ps;
	// ==========
	// signals and instances
	logic clk = 0, resetn = 0, power_good = 0, req_valid = 0, req_write = 0;
	logic [14:0] req_addr = 15'h0000;
	logic [7:0] req_wdata = 8'h00;
	wire req_ready, rsp_valid, mem_available, chip_select_n, write_enable_n, output_gate_n;
	wire data_lines_oe, rst_pull, supervisor_reset_n;
	wire [7:0] rsp_rdata, data_lines_out, data_lines_in;
	wire [14:0] address_lines;
	int err_total = 0, compares = 0, cyc = 0;
	assign supervisor_reset_n = !rst_pull;
	always #2 clk = ~clk;
	nvsram_host #(.LOCKOUT_CYCLES(26'h0000014)) i_nvsram_host (.clk, .resetn, .power_good,
		.supervisor_reset_n, .req_valid, .req_write, .req_addr, .req_wdata, .req_ready,
		.rsp_valid, .rsp_rdata, .mem_available, .address_lines, .chip_select_n,
		.write_enable_n, .output_gate_n, .data_lines_in, .data_lines_out, .data_lines_oe);
	nvsram_device_model i_nvsram_device_model (.clk, .power_good, .address_lines,
		.chip_select_n, .write_enable_n, .output_gate_n, .data_lines_out, .data_lines_oe,
		.data_lines_in, .rst_pull);
	task automatic end_sim;
		if (err_total == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// hold the request until an edge takes it, then wait for the answer if wt is set
	task automatic xfer(input logic w, input logic [14:0] a, input logic [7:0] d, input int wt);
		int n;
		@(posedge clk);
		req_valid <= 1'b1;
		req_write <= w;
		req_addr <= a;
		req_wdata <= d;
		n = 0;
		@(negedge clk);
		while (req_ready !== 1'b1 && n < 200) begin
			@(negedge clk);
			n++;
		end
		@(posedge clk);
		req_valid <= 1'b0;
		`CHK(n < 200, 1'b1, "request not taken")
		n = 0;
		while (wt && rsp_valid !== 1'b1 && n < 100) begin
			@(negedge clk);
			n++;
		end
		if (wt) `CHK(rsp_valid, 1'b1, "no answer")
	endtask
	// lockout first, then both ends of the address space back to back
	task automatic t_rw;
		`CHK(req_ready, 1'b0, "ready in lockout")
		xfer(1'b1, 15'h0000, 8'h5a, 1);
		xfer(1'b1, 15'h7fff, 8'ha5, 1);
		`CHK(mem_available, 1'b1, "lockout stuck")
		xfer(1'b0, 15'h0000, 8'h00, 1);
		`CHK(rsp_rdata, 8'h5a, "read low end")
		xfer(1'b0, 15'h7fff, 8'h00, 1);
		`CHK(rsp_rdata, 8'ha5, "read high end")
	endtask
	// supply lost in mid-write: pins go quiet and the old byte survives
	task automatic t_power;
		xfer(1'b1, 15'h0000, 8'h3c, 0);
		repeat (8) @(posedge clk);
		power_good <= 1'b0;
		repeat (2) @(negedge clk);
		`CHK({chip_select_n, write_enable_n, data_lines_oe}, 3'b110, "pins live")
		`CHK(req_ready, 1'b0, "ready off supply")
		@(posedge clk);
		power_good <= 1'b1;
		@(negedge clk);
		`CHK(mem_available, 1'b0, "no lockout")
		xfer(1'b0, 15'h0000, 8'h00, 1);
		`CHK(rsp_rdata, 8'h5a, "write not blocked")
	endtask
	initial begin
		repeat (8) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		power_good <= 1'b1;
		@(negedge clk);
		t_rw();
		t_power();
		end_sim();
	end
	// hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			err_total++;
			end_sim();
		end
	end
endmodule // nvsram_host_bench
`default_nettype wire
